// ---- core/debug_trap_unit_regs.vh ----
// Constants for the debug trap unit: vectors, field positions, reset values, trace store
`ifndef DEBUG_TRAP_UNIT_REGS_VH
`define DEBUG_TRAP_UNIT_REGS_VH

`define DEBUG_VECTOR 32'h00000ff0
`define DEBUG_TRAP_TYPE 8'hff
`define DEBUG_TRAP_PRIORITY 4'h2
`define TRACE_BASE 32'h0000ff40
`define TRACE_DEPTH 16

// Debug control word fields
`define CTL_SS 4
`define CTL_INSTR_BREAK_ENABLE_ONE 5
`define CTL_INSTR_BREAK_ENABLE_TWO 6
`define CTL_BG 9
`define CTL_BREAK_WHEN_TRAPS_DISABLED 10
`define CTL_SWF 13
`define CTL_US1 14
`define CTL_US2 15
`define CTL_RESET 32'h00000400

// Debug status word fields
`define STS_MODE 1
`define STS_EB 6
`define STS_PET 8
`define STS_PPS 9
`define STS_PTR_LO 12
`define STS_PTR_HI 15

`endif

// ---- core/debug_trap_unit.v ----
// Debug trap unit: mode strap, break sources, state save/restore, PC trace
`timescale 1ns/1ns
`include "debug_trap_unit_regs.vh"

// Operation
// - Latched mode bit reads 0 for debug mode, 1 for normal mode.
// - Strap captured at reset release; software cannot change it until reset.
// - Normal mode disables all breaks and gates the unit's logic off; control word writes still take effect here.
// - Strap and break both low at release jump directly to debug vector.
// - Software flag clears on reset and keeps whatever software writes.
// - Break pin falling edge sets external-break flag and starts async trap.
// - Break pin ignored in normal mode and while debug routine runs.
// - PC match with privilege and enable gives a trap before execution.
// - Single step traps after each instruction except return and state writes.
// - Software break instruction traps only while mode bit reads 0.
// - Debug traps have priority 2, below only reset.
// - Every debug trap uses type 255 and the fixed vector.
// - Traps disabled: hardware/external breaks need break-when-disabled; software always.
// - Debug traps run supervisor only and never nest.
// - With routine active, no debug trap is raised, not even for the software break instruction.
// - Entry saves trap-enable and supervisor, sets active; type 255 for software.
// - Jump-link plus trap-return while active clears it and restores bits.
// - Saved supervisor and trap-enable read at status bits 9 and 8.
// - Debug-active pin follows the routine-active bit; marks uncached accesses.
// - Debug trap decrements the current window pointer like any trap.
// - Debug mode records each fetch address outside the routine in a 16-entry cyclic store.
// - Pointer marks newest entry; its address is pointer<<2 ORed with base.
// - External-break flag reads 1 after a break; writing 0 clears it.
// - Trace pointer sits read-only in status bits 15 to 12.
module debug_trap_unit (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Pins
    input wire debug_enable_strap_n,
    input wire external_break_pin_n,
    output reg debug_active_pin,
    // Core pipeline view
    input wire fetch_valid,
    input wire [31:0] fetch_addr,
    input wire issue_valid,
    input wire [31:0] issue_pc,
    input wire retire_valid,
    input wire retire_no_step,
    input wire software_break_instr,
    input wire trap_return_instr,
    input wire trap_enable_bit,
    input wire prior_supervisor_state,
    input wire supervisor_state,
    input wire [4:0] current_window_pointer,
    // Software control word
    input wire ctl_write,
    input wire [31:0] ctl_wdata,
    input wire status_write,
    input wire [31:0] status_wdata,
    input wire [31:0] instr_break_addr_one,
    input wire [31:0] instr_break_addr_two,
    // Trace store read port
    input wire [3:0] trace_rd_index,
    output reg [31:0] trace_rd_data,
    // Trap request to the core
    output reg trap_req,
    output reg trap_before_exec,
    output reg [31:0] trap_vector,
    output reg [7:0] trap_type,
    output reg trap_type_write,
    output reg [3:0] trap_priority,
    output reg [4:0] new_window_pointer,
    output reg restore_req,
    output reg restore_trap_enable,
    output reg restore_supervisor,
    output reg boot_debug_jump,
    // Register views
    output reg [31:0] debug_control_register,
    output reg [31:0] debug_status_register
);

////////////////////////////////////////////////////////////////////////////////
// Reset release

reg rst_meta_reg;
reg rst_sync_reg;
wire rst_n = rst_sync_reg;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        rst_meta_reg <= 1'b0;
        rst_sync_reg <= 1'b0;
    end else begin
        rst_meta_reg <= 1'b1;
        rst_sync_reg <= rst_meta_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Mode strap capture

reg strap_done_reg;
reg latched_debug_mode_bit;
wire debug_mode = strap_done_reg && !latched_debug_mode_bit;
// Clock gate stand-in: break sources and trace store idle in normal mode
wire unit_on = debug_mode;

// Strap taken once, at the first edge after release
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        strap_done_reg <= 1'b0;
        latched_debug_mode_bit <= 1'b1;
    end else if (!strap_done_reg) begin
        strap_done_reg <= 1'b1;
        latched_debug_mode_bit <= debug_enable_strap_n;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Break pin synchroniser and edge

reg brk_meta_reg;
reg brk_sync_reg;
reg brk_prev_reg;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        brk_meta_reg <= 1'b1;
        brk_sync_reg <= 1'b1;
        brk_prev_reg <= 1'b1;
    end else begin
        brk_meta_reg <= external_break_pin_n;
        brk_sync_reg <= brk_meta_reg;
        brk_prev_reg <= brk_sync_reg;
    end
end

wire brk_fall = brk_prev_reg && !brk_sync_reg;

////////////////////////////////////////////////////////////////////////////////
// Control state

reg ss_reg;
reg instr_break_enable_one_reg;
reg instr_break_enable_two_reg;
reg break_when_traps_disabled_reg;
reg swf_reg;
reg us1_reg;
reg us2_reg;
reg debug_routine_active;
reg saved_trap_enable;
reg saved_supervisor_bit;
reg external_break_flag;
reg boot_pending_reg;
reg [3:0] trace_pointer;

// Hardware and external breaks need traps on, or break-when-disabled
wire hw_allowed = trap_enable_bit || break_when_traps_disabled_reg;
wire idle = unit_on && !debug_routine_active;

wire ext_hit = idle && hw_allowed && brk_fall;
wire ia1_hit = instr_break_enable_one_reg && (issue_pc[31:2] == instr_break_addr_one[31:2]) &&
               (supervisor_state == us1_reg);
wire ia2_hit = instr_break_enable_two_reg && (issue_pc[31:2] == instr_break_addr_two[31:2]) &&
               (supervisor_state == us2_reg);
wire ia_hit = idle && hw_allowed && issue_valid && (ia1_hit || ia2_hit);
wire ss_hit = idle && hw_allowed && ss_reg && retire_valid && !retire_no_step;
// Software break honoured regardless of trap enable; entry still blocked while a routine is active
wire sw_hit = unit_on && software_break_instr;
wire boot_hit = boot_pending_reg && unit_on;
wire take = ext_hit || ia_hit || ss_hit || sw_hit || boot_hit;
// Returning from the routine
wire ret_hit = debug_routine_active && trap_return_instr;

// Software control fields
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        ss_reg <= 1'b0;
        instr_break_enable_one_reg <= 1'b0;
        instr_break_enable_two_reg <= 1'b0;
        break_when_traps_disabled_reg <= 1'b1;
        swf_reg <= 1'b0;
        us1_reg <= 1'b0;
        us2_reg <= 1'b0;
    end else if (ctl_write) begin
        ss_reg <= ctl_wdata[`CTL_SS];
        instr_break_enable_one_reg <= ctl_wdata[`CTL_INSTR_BREAK_ENABLE_ONE];
        instr_break_enable_two_reg <= ctl_wdata[`CTL_INSTR_BREAK_ENABLE_TWO];
        break_when_traps_disabled_reg <= ctl_wdata[`CTL_BREAK_WHEN_TRAPS_DISABLED];
        swf_reg <= ctl_wdata[`CTL_SWF];
        us1_reg <= ctl_wdata[`CTL_US1];
        us2_reg <= ctl_wdata[`CTL_US2];
    end
end

// Strap and break pin both low at release: monitor entry instead of address zero
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        boot_pending_reg <= 1'b0;
    end else if (!strap_done_reg) begin
        boot_pending_reg <= !debug_enable_strap_n && !external_break_pin_n;
    end else if (boot_hit) begin
        boot_pending_reg <= 1'b0;
    end
end

// Set wins over a simultaneous software clear
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        external_break_flag <= 1'b0;
    end else if (ext_hit || boot_hit) begin
        external_break_flag <= 1'b1;
    end else if (status_write && !status_wdata[`STS_EB]) begin
        external_break_flag <= 1'b0;
    end
end

// Routine state; a second trap cannot overwrite the saved copies
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        debug_routine_active <= 1'b0;
        saved_trap_enable <= 1'b0;
        saved_supervisor_bit <= 1'b0;
    end else if (take && !debug_routine_active) begin
        saved_trap_enable <= trap_enable_bit;
        saved_supervisor_bit <= prior_supervisor_state;
        debug_routine_active <= 1'b1;
    end else if (ret_hit) begin
        debug_routine_active <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Trap request outputs

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        trap_req <= 1'b0;
        trap_before_exec <= 1'b0;
        trap_vector <= 32'h00000000;
        trap_type <= 8'h00;
        trap_type_write <= 1'b0;
        trap_priority <= 4'h0;
        new_window_pointer <= 5'h00;
        boot_debug_jump <= 1'b0;
    end else begin
        // Nested entry blocked while a routine is live
        trap_req <= take && !debug_routine_active;
        trap_before_exec <= ia_hit;
        trap_vector <= `DEBUG_VECTOR;
        trap_type <= `DEBUG_TRAP_TYPE;
        trap_type_write <= sw_hit && !debug_routine_active;
        trap_priority <= `DEBUG_TRAP_PRIORITY;
        new_window_pointer <= current_window_pointer - 5'h01;
        boot_debug_jump <= boot_hit;
    end
end

// Return path and routine pin
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        restore_req <= 1'b0;
        restore_trap_enable <= 1'b0;
        restore_supervisor <= 1'b0;
        debug_active_pin <= 1'b0;
    end else begin
        restore_req <= ret_hit;
        restore_trap_enable <= saved_trap_enable;
        restore_supervisor <= saved_supervisor_bit;
        // One cycle behind the bit, a flop as every output must be
        debug_active_pin <= debug_routine_active;
    end
end

////////////////////////////////////////////////////////////////////////////////
// PC trace store

reg [31:0] trace_mem [0:`TRACE_DEPTH-1];
wire trace_we = unit_on && !debug_routine_active && fetch_valid;
// Kept at four bits so the step past entry 15 wraps to entry 0
wire [3:0] trace_wr_index = trace_pointer + 4'h1;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        trace_pointer <= 4'hf;
    end else if (trace_we) begin
        trace_pointer <= trace_pointer + 4'h1;
    end
end

genvar gi;
generate
    for (gi = 0; gi < `TRACE_DEPTH; gi = gi + 1) begin : trace_entry
        always @(posedge mclk) begin
            if (trace_we && (trace_wr_index == gi)) begin
                trace_mem[gi] <= fetch_addr;
            end
        end
    end
endgenerate

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        trace_rd_data <= 32'h00000000;
    end else begin
        trace_rd_data <= trace_mem[trace_rd_index];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register views

// Views assembled field by field; reserved bits stay zero
reg [31:0] ctl_view_next;
reg [31:0] status_view_next;

always @* begin
    ctl_view_next = 32'h00000000;
    ctl_view_next[`CTL_SS] = ss_reg;
    ctl_view_next[`CTL_INSTR_BREAK_ENABLE_ONE] = instr_break_enable_one_reg;
    ctl_view_next[`CTL_INSTR_BREAK_ENABLE_TWO] = instr_break_enable_two_reg;
    ctl_view_next[`CTL_BG] = debug_routine_active;
    ctl_view_next[`CTL_BREAK_WHEN_TRAPS_DISABLED] = break_when_traps_disabled_reg;
    ctl_view_next[`CTL_SWF] = swf_reg;
    ctl_view_next[`CTL_US1] = us1_reg;
    ctl_view_next[`CTL_US2] = us2_reg;
end

always @* begin
    status_view_next = 32'h00000000;
    status_view_next[`STS_MODE] = latched_debug_mode_bit;
    status_view_next[`STS_EB] = external_break_flag;
    status_view_next[`STS_PET] = saved_trap_enable;
    status_view_next[`STS_PPS] = saved_supervisor_bit;
    status_view_next[`STS_PTR_HI:`STS_PTR_LO] = trace_pointer;
end

// Reset value matches the pointer's reset, so no step at release
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        debug_control_register <= `CTL_RESET;
        debug_status_register <= 32'h0000f002;
    end else begin
        debug_control_register <= ctl_view_next;
        debug_status_register <= status_view_next;
    end
end

endmodule

// ---- verification/debug_trap_unit_properties.sv ----
// Port-level assertions for the debug trap unit
`timescale 1ns/1ns
module debug_trap_unit_checker (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Core inputs
    input wire software_break_instr,
    input wire trap_return_instr,
    input wire trap_enable_bit,
    input wire prior_supervisor_state,
    // Unit outputs
    input wire debug_active_pin,
    input wire trap_req,
    input wire trap_type_write,
    input wire [31:0] trap_vector,
    input wire [7:0] trap_type,
    input wire [3:0] trap_priority,
    input wire restore_req,
    input wire boot_debug_jump,
    input wire [31:0] debug_control_register,
    input wire [31:0] debug_status_register
);
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
////////////////////////////////////////
mode_hold_a: assert property (!$past(debug_status_register[1]) |-> !debug_status_register[1])
    else $error("mode bit left debug mode");
normal_quiet_a: assert property (debug_status_register[1] && !boot_debug_jump |-> !trap_req)
    else $error("trap raised in normal mode");
sw_trap_a: assert property (software_break_instr && !debug_status_register[1] &&
    !debug_control_register[9] |=> trap_req && trap_type_write)
    else $error("software break gave no trap");
trap_fields_a: assert property (trap_req |-> trap_vector == 32'h00000ff0 &&
    trap_type == 8'hff && trap_priority == 4'h2)
    else $error("trap vector, type or priority wrong");
pin_follow_a: assert property (debug_active_pin == debug_control_register[9])
    else $error("active pin does not follow active bit");
active_gate_a: assert property (debug_control_register[9] && !software_break_instr
    |=> !trap_req)
    else $error("trap raised while routine active");
return_clear_a: assert property (trap_return_instr && debug_control_register[9]
    |=> restore_req ##1 !debug_control_register[9] && !debug_active_pin)
    else $error("return did not restore and clear");
saved_bits_a: assert property (trap_req && trap_type_write |=>
    debug_status_register[9] == $past(prior_supervisor_state, 2) &&
    debug_status_register[8] == $past(trap_enable_bit, 2))
    else $error("saved state bits wrong");
endmodule
bind debug_trap_unit debug_trap_unit_checker i_debug_trap_unit_checker (.mclk, .reset_n,
    .software_break_instr, .trap_return_instr, .trap_enable_bit, .prior_supervisor_state,
    .debug_active_pin, .trap_req, .trap_type_write, .trap_vector, .trap_type, .trap_priority,
    .restore_req, .boot_debug_jump, .debug_control_register, .debug_status_register);

// ---- verification/debug_probe_model.sv ----
// Debug probe model: drives the mode strap and the break pin
`timescale 1ns/1ns
module debug_probe_model (
    // Clock
    input wire mclk,
    // Probe pins, pulled high when idle
    output reg debug_enable_strap_n = 1'h1,
    output reg external_break_pin_n = 1'h1
);
////////////////////////////////////////
// Called at a falling edge, held well past reset release
task set_pins(input s, input b);
    begin
        debug_enable_strap_n = s;
        external_break_pin_n = b;
    end
endtask
// Three cycles low: above the two-cycle minimum width
task pulse_break;
    begin
        @(negedge mclk);
        external_break_pin_n = 1'h0;
        repeat (3) @(negedge mclk);
        external_break_pin_n = 1'h1;
    end
endtask
endmodule

// ---- verification/tb_debug_trap_unit.sv ----
// Self-checking bench for the debug trap unit
`timescale 1ns/1ns
module tb_debug_trap_unit;
reg mclk = 1'h0, reset_n = 1'h0, fetch_valid = 1'h0, issue_valid = 1'h0;
reg retire_valid = 1'h0, retire_no_step = 1'h0, software_break_instr = 1'h0;
reg trap_return_instr = 1'h0, trap_enable_bit = 1'h1, prior_supervisor_state = 1'h0;
reg supervisor_state = 1'h1, ctl_write = 1'h0, status_write = 1'h0;
reg [4:0] current_window_pointer = 5'h0;
reg [3:0] trace_rd_index = 4'h0;
reg [31:0] fetch_addr = 32'h0, issue_pc = 32'h0, ctl_wdata = 32'h0, status_wdata = 32'h0;
reg [31:0] instr_break_addr_one = 32'h0, instr_break_addr_two = 32'h4;
reg [7:0] rnd = 8'h2d;
reg [31:0] hist [0:19];
integer miscompares = 0, comparisons = 0, trap_count = 0, boot_count = 0, i, k, n;
wire debug_enable_strap_n, external_break_pin_n, debug_active_pin, trap_req, trap_before_exec;
wire trap_type_write, restore_req, restore_trap_enable, restore_supervisor, boot_debug_jump;
wire [31:0] trace_rd_data, trap_vector, debug_control_register, debug_status_register;
wire [7:0] trap_type;
wire [3:0] trap_priority;
wire [4:0] new_window_pointer;
debug_trap_unit i_debug_trap_unit (.mclk, .reset_n, .debug_enable_strap_n,
    .external_break_pin_n, .debug_active_pin, .fetch_valid, .fetch_addr, .issue_valid,
    .issue_pc, .retire_valid, .retire_no_step, .software_break_instr, .trap_return_instr,
    .trap_enable_bit, .prior_supervisor_state, .supervisor_state, .current_window_pointer,
    .ctl_write, .ctl_wdata, .status_write, .status_wdata, .instr_break_addr_one,
    .instr_break_addr_two, .trace_rd_index, .trace_rd_data, .trap_req, .trap_before_exec,
    .trap_vector, .trap_type, .trap_type_write, .trap_priority, .new_window_pointer,
    .restore_req, .restore_trap_enable, .restore_supervisor, .boot_debug_jump,
    .debug_control_register, .debug_status_register);
debug_probe_model i_debug_probe_model (.mclk, .debug_enable_strap_n, .external_break_pin_n);
////////////////////////////////////////
initial forever #5 mclk = ~mclk;
// Pulses are counted so none is missed between spot checks
always @(posedge mclk) begin
    trap_count <= trap_count + trap_req;
    boot_count <= boot_count + boot_debug_jump;
end
function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
endfunction
task chk(input [31:0] seen, input [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
endtask
task results;
    begin
        $display("%0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
endtask
task automatic pulse(ref logic s);
    begin
        s = 1'h1;
        @(negedge mclk);
        s = 1'h0;
    end
endtask
task wr_ctl(input [31:0] v);
    begin
        ctl_wdata = v;
        pulse(ctl_write);
        @(negedge mclk);
    end
endtask
task do_reset(input s, input b);
    begin
        i_debug_probe_model.set_pins(s, b);
        reset_n = 1'h0;
        repeat (20) @(negedge mclk);
        reset_n = 1'h1;
        repeat (3) @(negedge mclk);
        i_debug_probe_model.set_pins(1'h1, 1'h1);
        repeat (3) @(negedge mclk);
    end
endtask
initial begin
    #300000;
    miscompares = miscompares + 1;
    results;
end
////////////////////////////////////////
initial begin
    do_reset(1'h1, 1'h1);
    chk(debug_status_register, 32'hf002);
    chk(debug_control_register, 32'h400);
    pulse(software_break_instr);
    i_debug_probe_model.pulse_break;
    repeat (4) @(negedge mclk);
    chk(trap_count, 0);
    chk(debug_status_register[6], 0);
    $display("normal mode done");
    do_reset(1'h0, 1'h0);
    chk(boot_count, 1);
    chk(debug_status_register[6], 1);
    status_wdata = 32'h0;
    pulse(status_write);
    pulse(trap_return_instr);
    repeat (2) @(negedge mclk);
    chk(debug_status_register[6], 0);
    chk(debug_status_register[1], 0);
    wr_ctl(32'h2400);
    chk(debug_control_register[13], 1);
    $display("boot entry done");
    for (i = 0; i < 4; i = i + 1) begin
        rnd = lfsr(rnd);
        current_window_pointer = rnd[4:0];
        trap_enable_bit = rnd[5];
        prior_supervisor_state = rnd[6];
        n = trap_count;
        pulse(software_break_instr);
        chk({trap_req, trap_type_write, trap_type}, 32'h3ff);
        chk(trap_vector, 32'h00000ff0);
        chk(trap_priority, 32'h2);
        chk(new_window_pointer, 5'(rnd - 8'h1));
        @(negedge mclk);
        chk({debug_active_pin, debug_status_register[9:8]}, {1'h1, rnd[6:5]});
        i_debug_probe_model.pulse_break;
        repeat (4) @(negedge mclk);
        chk(trap_count - n, 1);
        chk(debug_status_register[6], 0);
        trap_enable_bit = ~rnd[5];
        prior_supervisor_state = ~rnd[6];
        pulse(trap_return_instr);
        chk({restore_req, restore_trap_enable, restore_supervisor}, {1'h1, rnd[5], rnd[6]});
        @(negedge mclk);
    end
    $display("software trap done");
    for (k = 0; k < 4; k = k + 1) begin
        rnd = lfsr(rnd);
        supervisor_state = (k != 1);
        trap_enable_bit = (k < 2);
        wr_ctl(k == 3 ? 32'h4420 : 32'h4020);
        instr_break_addr_one = {rnd, 24'h40};
        issue_pc = instr_break_addr_one;
        pulse(issue_valid);
        chk({trap_req, trap_before_exec}, (k == 0 || k == 3) ? 2'h3 : 2'h0);
        pulse(trap_return_instr);
        @(negedge mclk);
    end
    wr_ctl(32'h410);
    for (k = 0; k < 2; k = k + 1) begin
        retire_no_step = k;
        pulse(retire_valid);
        chk(trap_req, k == 0);
        pulse(trap_return_instr);
        @(negedge mclk);
    end
    wr_ctl(32'h400);
    $display("hardware break done");
    trap_enable_bit = 1'h1;
    n = trap_count;
    i_debug_probe_model.pulse_break;
    repeat (4) @(negedge mclk);
    chk(trap_count - n, 1);
    chk(debug_status_register[6], 1);
    pulse(status_write);
    pulse(trap_return_instr);
    repeat (2) @(negedge mclk);
    chk(debug_status_register[6], 0);
    $display("external break done");
    for (i = 0; i < 20; i = i + 1) begin
        rnd = lfsr(rnd);
        hist[i] = {rnd, 16'h0, ~rnd};
        fetch_addr = hist[i];
        pulse(fetch_valid);
        @(negedge mclk);
    end
    repeat (2) @(negedge mclk);
    chk(debug_status_register[15:12], 32'h3);
    for (i = 0; i < 16; i = i + 1) begin
        trace_rd_index = 4'(3 - i);
        @(negedge mclk);
        chk(trace_rd_data, hist[19 - i]);
    end
    $display("trace done");
    results;
end
endmodule
